/* File: verilog/ifc_map.svh */
// register offsets, fields, reset values and vectors of the flag controller
`ifndef IFC_MAP_SVH
`define IFC_MAP_SVH
`define IFC_OFS_CLEAR 8'h88
`define IFC_OFS_MODE 8'h8c
`define IFC_OFS_FLAGS 8'h90
`define IFC_OFS_STATUS 8'h94
`define IFC_OFS_MASK 8'h98
`define IFC_MODE_LEVEL_BIT 0
`define IFC_MODE_FALL_BIT 1
`define IFC_MODE_RESET 2'h0
`define IFC_VEC_EXT 6'h0a
`define IFC_VEC_RX_BASE 6'h18
`define IFC_VEC_DEFAULT 16'h0008
`define IFC_VADDR_HIGH 16'hffff
`define IFC_ST_EXT_BIT 0
`define IFC_ST_RX_BIT 1
`define IFC_ST_DEF_BIT 2
`endif

/* File: verilog/ifc_pkg.sv */
// types of the interrupt request flag controller
package ifc_pkg;
  // input mode of the external request
  typedef struct packed {
    logic falling; // edge/level polarity: 0 rising or high, 1 falling or low
    logic level;   // 0 edge mode, 1 level mode
  } ifc_mode_t;
  // vector fetch sequence after acceptance
  typedef enum logic [0:0] {IFC_IDLE, IFC_ACCEPTED} ifc_fetch_t;
endpackage : ifc_pkg

/* File: verilog/ifc_flag_ctrl.sv */
// interrupt request flags for the external request and serial receive sources
// Operation
// - cleared flag before vector read gives default vector
// - enable right after clear still sees old flag
// - level mode passes pin request straight through
// - edge to level switch clears the flag
// - level to edge switch keeps the flag
// - receive flag clears only by reset or read
// - clear write ignores receive vectors
// - level mode pin going inactive clears the request
// - edge mode clear register write of vector clears flag
`timescale 1ns/10ps
`include "ifc_map.svh"
module ifc_flag_ctrl import ifc_pkg::*; #(
  parameter int NRX = 3 // number of serial receive channels
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_pin_i,
  input wire logic [NRX-1:0] rx_done_i,
  input wire logic [NRX-1:0] rx_buf_read_i,
  input wire logic accept_i,
  input wire logic [3:0] accept_src_i,
  input wire logic vector_read_i,
  output logic ext_req_o,
  output logic [NRX-1:0] rx_req_o,
  output logic [15:0] vec_o,
  output logic [23:0] vaddr_o,
  output logic irq_o
);
  // refuse channel counts outside the range 1 to 8
  if (NRX < 1 || NRX > 8) begin : g_bad_nrx
    $error("NRX must lie between 1 and 8");
  end

  localparam int NF = NRX + 1; // ext flag plus receive flags

  logic pin_s1_reg, pin_s2_reg, pin_d_reg; // synchroniser and delay
  ifc_mode_t mode_reg, mode_next; // input mode control
  logic ext_ff_reg, ext_ff_next; // external request flip-flop
  logic [NRX-1:0] rx_flag_reg, rx_flag_next; // receive flags
  logic [2:0] sts_reg, sts_next; // sticky event status
  logic [2:0] mask_reg, mask_next; // interrupt mask
  ifc_fetch_t st_reg, st_next; // vector fetch state
  logic [3:0] src_reg, src_next; // accepted source
  logic stale_reg, stale_next; // accepted flag got cleared
  logic [15:0] vec_next;
  logic [31:0] dat_next;
  logic ack_next;
  logic ext_q_reg; // previous ext flag for event detect
  logic [NRX-1:0] rx_q_reg; // previous receive flags

  // bus decode, one-cycle ack per request
  logic req, wr, rd, wr_mode, wr_clr, rd_sts;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wr_mode = wr & (wb_adr_i == `IFC_OFS_MODE);
  assign wr_clr = wr & (wb_adr_i == `IFC_OFS_CLEAR);
  assign rd_sts = rd & (wb_adr_i == `IFC_OFS_STATUS);

  // pin requests seen through the synchroniser
  logic lvl_req, edge_hit, clr_ext, to_level, to_edge, ext_flag;
  assign lvl_req = pin_s2_reg ^ mode_reg.falling;
  assign edge_hit = mode_reg.falling ? (pin_d_reg & ~pin_s2_reg) : (~pin_d_reg & pin_s2_reg);
  assign clr_ext = wr_clr & (wb_dat_i[5:0] == `IFC_VEC_EXT);
  assign to_level = wr_mode & wb_dat_i[`IFC_MODE_LEVEL_BIT] & ~mode_reg.level;
  assign to_edge = wr_mode & ~wb_dat_i[`IFC_MODE_LEVEL_BIT] & mode_reg.level;
  // level mode bypasses the flip-flop
  assign ext_flag = mode_reg.level ? lvl_req : ext_ff_reg;

  // flags of all sources, index 0 is the external request
  logic [NF-1:0] flags;
  assign flags = {rx_flag_reg, ext_flag};
  logic src_flag; // flag of the accepted source, read by the fetch logic

  // next state of mode and request flags
  always_comb begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next.level = wb_dat_i[`IFC_MODE_LEVEL_BIT];
      mode_next.falling = wb_dat_i[`IFC_MODE_FALL_BIT];
    end
    // flip-flop tracks the level request so a level flag survives
    if (mode_reg.level) begin
      ext_ff_next = lvl_req;
    end else if (to_level) begin
      ext_ff_next = 1'b0;
    end else if (edge_hit) begin
      ext_ff_next = 1'b1;
    end else if (clr_ext) begin
      ext_ff_next = 1'b0;
    end else begin
      ext_ff_next = ext_ff_reg;
    end
    // receive flags ignore the clear register, set wins over read
    rx_flag_next = (rx_flag_reg & ~rx_buf_read_i) | rx_done_i;
  end

  // vector fetch: remember source, watch its flag
  always_comb begin
    st_next = st_reg;
    src_next = src_reg;
    stale_next = stale_reg;
    vec_next = vec_o;
    case (st_reg)
      IFC_IDLE: begin
        if (accept_i) begin
          st_next = IFC_ACCEPTED;
          src_next = accept_src_i;
          stale_next = 1'b0;
        end
      end
      IFC_ACCEPTED: begin
        // flag cleared in between: default vector
        if (vector_read_i) begin
          st_next = IFC_IDLE;
          if (stale_reg || !src_flag) begin
            vec_next = `IFC_VEC_DEFAULT;
          end else if (src_reg == 4'h0) begin
            vec_next = {8'h00, `IFC_VEC_EXT, 2'b00};
          end else begin
            vec_next = {8'h00, `IFC_VEC_RX_BASE + 6'(src_reg - 4'h1), 2'b00};
          end
        end else if (!src_flag) begin
          stale_next = 1'b1;
        end
      end
      default: begin
        st_next = IFC_IDLE;
      end
    endcase
  end

  // flag of the accepted source, zero for unknown index
  always_comb begin
    src_flag = 1'b0;
    for (int i = 0; i < NF; i++) begin
      if (src_reg == 4'(i)) begin
        src_flag = flags[i];
      end
    end
  end

  // sticky events, set wins over read clear
  logic [2:0] ev;
  always_comb begin
    ev = 3'h0;
    ev[`IFC_ST_EXT_BIT] = ext_flag & ~ext_q_reg;
    ev[`IFC_ST_RX_BIT] = |(rx_flag_reg & ~rx_q_reg);
    ev[`IFC_ST_DEF_BIT] = (st_reg == IFC_ACCEPTED) & vector_read_i & (stale_reg | ~src_flag);
    sts_next = (rd_sts ? 3'h0 : sts_reg) | ev;
    mask_next = mask_reg;
    if (wr && wb_adr_i == `IFC_OFS_MASK) begin
      mask_next = wb_dat_i[2:0];
    end
  end

  // read data; unmapped and clear register read as zero
  always_comb begin
    dat_next = 32'h0;
    ack_next = req;
    if (rd) begin
      case (wb_adr_i)
        `IFC_OFS_MODE: dat_next = {30'h0, mode_reg};
        `IFC_OFS_FLAGS: dat_next = {{(32 - NF){1'b0}}, flags};
        `IFC_OFS_STATUS: dat_next = {29'h0, sts_reg};
        `IFC_OFS_MASK: dat_next = {29'h0, mask_reg};
        default: dat_next = 32'h0;
      endcase
    end
  end

  // registers; outputs lag one cycle so a fresh clear is not yet seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg <= 1'b0;
      mode_reg <= `IFC_MODE_RESET;
      ext_ff_reg <= 1'b0;
      rx_flag_reg <= '0;
      sts_reg <= 3'h0;
      mask_reg <= 3'h0;
      st_reg <= IFC_IDLE;
      src_reg <= 4'h0;
      stale_reg <= 1'b0;
      vec_o <= `IFC_VEC_DEFAULT;
      vaddr_o <= 24'h0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      ext_req_o <= 1'b0;
      rx_req_o <= '0;
      irq_o <= 1'b0;
      ext_q_reg <= 1'b0;
      rx_q_reg <= '0;
    end else begin
      pin_s1_reg <= ext_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      mode_reg <= mode_next;
      ext_ff_reg <= ext_ff_next;
      rx_flag_reg <= rx_flag_next;
      sts_reg <= sts_next;
      mask_reg <= mask_next;
      st_reg <= st_next;
      src_reg <= src_next;
      stale_reg <= stale_next;
      vec_o <= vec_next;
      vaddr_o <= {`IFC_VADDR_HIGH, vec_next[7:0]};
      wb_dat_o <= dat_next;
      wb_ack_o <= ack_next;
      ext_req_o <= ext_flag;
      rx_req_o <= rx_flag_reg;
      irq_o <= |(sts_reg & mask_reg);
      ext_q_reg <= ext_flag;
      rx_q_reg <= rx_flag_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // steps of a lost request
  sequence s_drop;
    st_reg == IFC_ACCEPTED && !src_flag;
  endsequence
  sequence s_take;
    vector_read_i;
  endsequence
  property p_default_vec;
    s_drop ##0 s_take |=> vec_o == `IFC_VEC_DEFAULT && vaddr_o == 24'hffff08;
  endproperty
  a_default_vec: assert property (p_default_vec) else $error("default vector not given");
  // a same-cycle edge wins over the clear, so it is left out
  property p_late_clear;
    clr_ext && ext_flag && !edge_hit && !mode_reg.level |=> ext_req_o ##1 !ext_req_o;
  endproperty
  a_late_clear: assert property (p_late_clear) else $error("clear timing wrong");
  property p_bypass;
    mode_reg.level && !wr_mode |=> ext_req_o == $past(lvl_req);
  endproperty
  a_bypass: assert property (p_bypass) else $error("level request not passed");
  property p_to_level;
    to_level |=> !ext_ff_reg;
  endproperty
  a_to_level: assert property (p_to_level) else $error("switch to level kept flag");
  property p_to_edge;
    to_edge |=> ext_ff_reg == $past(lvl_req) ##1 ext_req_o == $past(lvl_req, 2);
  endproperty
  a_to_edge: assert property (p_to_edge) else $error("level flag lost at edge switch");
  property p_rx_clear;
    (($past(rx_flag_reg) & ~rx_flag_reg & ~$past(rx_buf_read_i)) == '0);
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag cleared wrongly");
  property p_rx_ignore;
    wr_clr && rx_buf_read_i == '0 |=> (rx_flag_reg & $past(rx_flag_reg)) == $past(rx_flag_reg);
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("clear write hit receive flag");
  property p_pin_fall;
    mode_reg.level && !wr_mode && !lvl_req |=> !ext_req_o;
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("level request not dropped");
  property p_clear;
    clr_ext && !edge_hit && !mode_reg.level && !wr_mode |=> !ext_ff_reg ##1 !ext_req_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear write ignored");
  property p_edge_set;
    !mode_reg.level && !wr_mode && edge_hit |=> ext_ff_reg;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not latched");
  // receive set wins over a buffer read in the same cycle
  property p_rx_set;
    |rx_done_i |=> (rx_flag_reg & $past(rx_done_i)) == $past(rx_done_i);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive event lost");
  // bus answer is a single-cycle pulse
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  // status bits stay until a status read
  property p_sts_sticky;
    !rd_sts |=> (sts_reg & $past(sts_reg)) == $past(sts_reg);
  endproperty
  a_sts_sticky: assert property (p_sts_sticky) else $error("status bit lost");
  // fetch state leaves idle only on acceptance
  property p_fetch_idle;
    st_reg == IFC_IDLE && !accept_i |=> st_reg == IFC_IDLE;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch left idle");
endmodule : ifc_flag_ctrl

/* File: bench/ifc_ext_src.sv */
// model of the external source that drives the request pin
`timescale 1ns/10ps
module ifc_ext_src (
  input wire logic clk_i, // system clock
  output logic pin_o // request pin level
);
  // pin idles low until the first request
  initial begin
    pin_o = 1'b0;
  end
  // drive a level and hold it clean for n cycles
  task automatic drive(input logic v, input int n);
    pin_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : drive
endmodule : ifc_ext_src

/* File: bench/tb.sv */
// self-checking bench of the interrupt request flag controller
`timescale 1ns/10ps
`include "ifc_map.svh"
module tb;
  logic clk_i = 1'b0; // 100 mhz clock
  logic rst_i = 1'b1; // reset, active high
  logic [7:0] wb_adr_i = 8'h00; // bus address
  logic [31:0] wb_dat_i = 32'h0; // bus write data
  logic [3:0] wb_sel_i = 4'h0; // byte enables
  logic wb_we_i = 1'b0; // bus direction
  logic wb_cyc_i = 1'b0; // bus cycle
  logic wb_stb_i = 1'b0; // bus strobe
  logic [31:0] wb_dat_o; // read data
  logic wb_ack_o; // bus answer
  logic ext_pin; // pin from source model
  logic [2:0] rx_done_i = 3'h0; // receive done pulses
  logic [2:0] rx_buf_read_i = 3'h0; // buffer read pulses
  logic accept_i = 1'b0; // cpu acceptance
  logic [3:0] accept_src_i = 4'h0; // accepted source
  logic vector_read_i = 1'b0; // vector read
  logic ext_req_o; // external flag
  logic [2:0] rx_req_o; // receive flags
  logic [15:0] vec_o; // fetched vector
  logic [23:0] vaddr_o; // vector address
  logic irq_o; // interrupt line
  logic [31:0] rdat; // last read data
  int err_total = 0; // mismatches
  int num_checks = 0; // comparisons
  ifc_flag_ctrl #(.NRX(3)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pin_i(ext_pin),
    .rx_done_i(rx_done_i), .rx_buf_read_i(rx_buf_read_i), .accept_i(accept_i),
    .accept_src_i(accept_src_i), .vector_read_i(vector_read_i), .ext_req_o(ext_req_o),
    .rx_req_o(rx_req_o), .vec_o(vec_o), .vaddr_o(vaddr_o), .irq_o(irq_o));
  ifc_ext_src u_src (.clk_i(clk_i), .pin_o(ext_pin));
  // free-running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // wait n rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // compare a value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one classic bus cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    rdat = wb_dat_o;
    chk({31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // print counts and verdict, then stop
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // cut a hang short
  initial begin
    tick(3000);
    err_total++;
    report_and_stop();
  end
  // test sequence
  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    chk(vec_o, `IFC_VEC_DEFAULT);
    bus(`IFC_OFS_MODE, 1'b0, 0);
    chk(rdat, 0);
    u_src.drive(1'b1, 8);
    u_src.drive(1'b0, 8);
    chk(ext_req_o, 1);
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h0b);
    chk(ext_req_o, 1);
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h0a);
    tick(3);
    chk(ext_req_o, 0);
    $display("test edge done");
    u_src.drive(1'b1, 8);
    accept_i <= 1'b1;
    tick(1);
    accept_i <= 1'b0;
    tick(2);
    vector_read_i <= 1'b1;
    tick(1);
    vector_read_i <= 1'b0;
    tick(2);
    chk(vec_o, 16'h0028);
    chk(vaddr_o, 24'hffff28);
    accept_i <= 1'b1;
    tick(1);
    accept_i <= 1'b0;
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h0a);
    vector_read_i <= 1'b1;
    tick(1);
    vector_read_i <= 1'b0;
    tick(2);
    chk(vec_o, 16'h0008);
    chk(vaddr_o, 24'hffff08);
    $display("test fetch done");
    u_src.drive(1'b0, 8);
    u_src.drive(1'b1, 8);
    u_src.drive(1'b0, 2);
    bus(`IFC_OFS_MODE, 1'b1, 32'h1);
    tick(3);
    chk(ext_req_o, 0);
    u_src.drive(1'b1, 6);
    chk(ext_req_o, 1);
    u_src.drive(1'b0, 6);
    chk(ext_req_o, 0);
    u_src.drive(1'b1, 6);
    bus(`IFC_OFS_MODE, 1'b1, 32'h0);
    u_src.drive(1'b0, 6);
    chk(ext_req_o, 1);
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h0a);
    tick(3);
    chk(ext_req_o, 0);
    $display("test level done");
    rx_done_i <= 3'h2;
    tick(1);
    rx_done_i <= 3'h0;
    tick(2);
    chk(rx_req_o, 3'h2);
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h19);
    tick(3);
    chk(rx_req_o, 3'h2);
    accept_src_i <= 4'h2;
    accept_i <= 1'b1;
    tick(1);
    accept_i <= 1'b0;
    vector_read_i <= 1'b1;
    tick(1);
    vector_read_i <= 1'b0;
    tick(1);
    chk(vec_o, 16'h0064);
    chk(vaddr_o, 24'hffff64);
    rx_buf_read_i <= 3'h2;
    tick(1);
    rx_buf_read_i <= 3'h0;
    tick(3);
    chk(rx_req_o, 3'h0);
    $display("test receive done");
    bus(`IFC_OFS_STATUS, 1'b0, 0);
    chk(rdat, 32'h7);
    bus(`IFC_OFS_MASK, 1'b1, 0);
    u_src.drive(1'b1, 8);
    chk(irq_o, 0);
    bus(`IFC_OFS_MASK, 1'b1, 32'h1);
    tick(2);
    chk(irq_o, 1);
    bus(`IFC_OFS_STATUS, 1'b0, 0);
    chk(rdat, 32'h1);
    tick(2);
    chk(irq_o, 0);
    bus(8'h40, 1'b0, 0);
    chk(rdat, 0);
    $display("test irq done");
    bus(`IFC_OFS_MODE, 1'b1, 32'h2);
    bus(`IFC_OFS_CLEAR, 1'b1, 32'h0a);
    chk(ext_req_o, 0);
    u_src.drive(1'b0, 8);
    chk(ext_req_o, 1);
    bus(`IFC_OFS_FLAGS, 1'b0, 0);
    chk(rdat, 32'h1);
    bus(`IFC_OFS_MODE, 1'b1, 32'h3);
    chk(ext_req_o, 1);
    u_src.drive(1'b1, 6);
    chk(ext_req_o, 0);
    $display("test falling done");
    report_and_stop();
  end
endmodule : tb
